// ### rtl/pdm_top.v
// Function
// RULE_01: sleep instruction with select clear enters sleep
// RULE_02: select set: sleep instruction enters software standby
// RULE_03: sleep halts cpu, registers keep contents
// RULE_04: crystal keep bit controls oscillator in standby
// RULE_05: reserved bits read zero, write zero
// RULE_06: two state pins encode reset/sleep/standby/normal
// RULE_07: rtc counts in software standby if started
// RULE_08: timer runs in standby from rtc clock
// RULE_09: hardware standby: rtc if started, timer stopped
// RULE_10: stopped timer pins hold, serial pins reset
// RULE_11: eight modules each stoppable on their own
// RULE_12: standby control is eight bits, resets zero
// RULE_13: module stop bit gates that module clock
// RULE_14: stopped rtc: registers inaccessible, counter runs
// RULE_15: interrupt/reset wake; pin low enters hardware standby
// RULE_16: sleep refreshes memory, standby uses self-refresh
//
// The register addresses and the plain strobed port are this design's own decisions.
`default_nettype none
`include "pdm_consts.vh"
module pdm_top (
    input wire clk,
    input wire rst,
    input wire [3:0] addr,
    input wire [7:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    output reg [7:0] rd_data,
    input wire sleep_exec,
    input wire wake_irq,
    input wire hw_standby_pin_n,
    input wire rtc_start,
    input wire tmu_src_rtc,
    output reg processor_state_hi,
    output reg processor_state_lo,
    output reg cpu_run,
    output reg cpg_run,
    output reg xtal_run,
    output reg [7:0] mod_clk_en,
    output reg rtc_count_en,
    output reg rtc_access_en,
    output reg tmu_pin_hold,
    output reg sci_pin_reset,
    output reg mem_refresh_en,
    output reg mem_self_refresh
);
    // ****************************************
    // address decode
    // ****************************************
    // shared by the write and read paths
    function hit;
        input [3:0] a;
        input [3:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // ****************************************
    // registers
    // ****************************************
    reg [7:0] standby_control_reg;
    reg [7:0] standby_control_next;
    reg [7:0] mod_stop_ext_reg;
    reg [7:0] mod_stop_ext_next;
    reg [7:0] rd_data_next;
    wire [1:0] mode;
    wire [7:0] stop_bits;
    wire [7:0] clk_en_w;
    wire cpg_run_w;
    wire xtal_run_w;
    wire rtc_count_w;
    wire rtc_access_w;
    wire soft_standby_select;
    wire standby_crystal_keep;
    wire in_sleep;
    wire in_standby;

    // field views of the control register
    assign soft_standby_select = standby_control_reg[`PDM_SC_SOFT_SOFT_STANDBY_SELECT];
    assign standby_crystal_keep = standby_control_reg[`PDM_SC_XTAL_KEEP];

    // stop vector: three bits here, five in the extension register
    assign stop_bits = {mod_stop_ext_reg[4:0],
                        standby_control_reg[`PDM_SC_STOP_TMU],
                        standby_control_reg[`PDM_SC_STOP_RTC],
                        standby_control_reg[`PDM_SC_STOP_SCI]}; // RULE_11

    // register write path; reserved bits are masked off on the way in
    always @* begin
        standby_control_next = standby_control_reg;
        mod_stop_ext_next = mod_stop_ext_reg;
        if (wr_en && hit(addr, `PDM_OFF_SOFT_STANDBY_SELECT_CTRL)) begin
            standby_control_next = wr_data & `PDM_SC_WR_MASK; // RULE_05 RULE_12
        end
        if (wr_en && hit(addr, `PDM_OFF_MOD_STOP_EXT)) begin
            mod_stop_ext_next = wr_data & `PDM_EXT_WR_MASK; // RULE_05
        end
    end

    // control registers clear on reset
    always @(posedge clk) begin
        if (rst) begin
            standby_control_reg <= `PDM_SC_RESET; // RULE_12
            mod_stop_ext_reg <= `PDM_EXT_RESET;
        end else begin
            standby_control_reg <= standby_control_next;
            mod_stop_ext_reg <= mod_stop_ext_next;
        end
    end

    // read path; unmapped offsets answer zero
    always @* begin
        rd_data_next = 8'h00;
        if (rd_en && hit(addr, `PDM_OFF_SOFT_STANDBY_SELECT_CTRL)) begin
            rd_data_next = standby_control_reg & `PDM_SC_WR_MASK; // RULE_05
        end else if (rd_en && hit(addr, `PDM_OFF_MOD_STOP_EXT)) begin
            rd_data_next = mod_stop_ext_reg & `PDM_EXT_WR_MASK;
        end
    end

    // read data stands one cycle only, zero otherwise
    always @(posedge clk) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= rd_data_next;
        end
    end

    // ****************************************
    // mode sequencing
    // ****************************************
    pdm_mode_fsm u_fsm (
        .clk(clk),
        .rst(rst),
        .sleep_exec(sleep_exec),
        .soft_standby_select(soft_standby_select),
        .wake_irq(wake_irq),
        .hw_standby_n(hw_standby_pin_n),
        .mode_reg(mode)
    );

    pdm_stop_ctrl u_stop (
        .mode(mode),
        .stop_bits(stop_bits),
        .xtal_keep(standby_crystal_keep),
        .rtc_start(rtc_start),
        .tmu_src_rtc(tmu_src_rtc),
        .clk_en(clk_en_w),
        .cpg_run(cpg_run_w),
        .xtal_run(xtal_run_w),
        .rtc_count_en(rtc_count_w),
        .rtc_access_en(rtc_access_w)
    );

    assign in_sleep = (mode == `PDM_MODE_SLEEP);
    assign in_standby = (mode == `PDM_MODE_SW_SOFT_STANDBY_SELECT) || (mode == `PDM_MODE_HW_SOFT_STANDBY_SELECT);

    // ****************************************
    // state pins
    // ****************************************
    // both high in reset; outputs lag the mode by one flop
    always @(posedge clk) begin
        if (rst) begin
            processor_state_hi <= 1'b1; // RULE_06
            processor_state_lo <= 1'b1; // RULE_06
        end else begin
            processor_state_hi <= in_sleep; // RULE_06
            processor_state_lo <= in_standby; // RULE_06
        end
    end

    // ****************************************
    // cpu, clock and pin control
    // ****************************************
    // cpu clock enable drops in every power-down mode, so registers hold
    always @(posedge clk) begin
        if (rst) begin
            cpu_run <= 1'b0;
            cpg_run <= 1'b1;
            xtal_run <= 1'b1;
            mod_clk_en <= 8'h00;
            rtc_count_en <= 1'b0;
            rtc_access_en <= 1'b0;
        end else begin
            cpu_run <= (mode == `PDM_MODE_NORMAL); // RULE_03
            cpg_run <= cpg_run_w; // RULE_02
            xtal_run <= xtal_run_w; // RULE_04
            mod_clk_en <= clk_en_w; // RULE_13
            rtc_count_en <= rtc_count_w; // RULE_07
            rtc_access_en <= rtc_access_w; // RULE_14
        end
    end

    // stopped timer freezes its pins, stopped serial returns to reset state
    always @(posedge clk) begin
        if (rst) begin
            tmu_pin_hold <= 1'b0;
            sci_pin_reset <= 1'b1;
        end else begin
            tmu_pin_hold <= stop_bits[`PDM_MOD_TMU]; // RULE_10
            sci_pin_reset <= stop_bits[`PDM_MOD_SCI]; // RULE_10
        end
    end

    // ****************************************
    // external memory refresh
    // ****************************************
    // self-refresh is needed because the bus clock halts in standby
    always @(posedge clk) begin
        if (rst) begin
            mem_refresh_en <= 1'b0;
            mem_self_refresh <= 1'b0;
        end else begin
            mem_refresh_en <= !in_standby; // RULE_16
            mem_self_refresh <= in_standby; // RULE_16
        end
    end
endmodule // pdm_top
`default_nettype wire

// ### shared/pdm_consts.vh
`ifndef PDM_CONSTS_VH
`define PDM_CONSTS_VH
// ****************************************
// register offsets
// ****************************************
`define PDM_OFF_SOFT_STANDBY_SELECT_CTRL 4'h0
`define PDM_OFF_MOD_STOP_EXT 4'h1
// ****************************************
// standby_control fields and reset
// ****************************************
`define PDM_SC_SOFT_SOFT_STANDBY_SELECT 7
`define PDM_SC_XTAL_KEEP 4
`define PDM_SC_STOP_TMU 2
`define PDM_SC_STOP_RTC 1
`define PDM_SC_STOP_SCI 0
`define PDM_SC_WR_MASK 8'h97
`define PDM_SC_RESET 8'h00
// ****************************************
// module stop extension fields and reset
// ****************************************
`define PDM_EXT_WR_MASK 8'h1f
`define PDM_EXT_RESET 8'h00
// ****************************************
// module index in the stop vector
// ****************************************
`define PDM_MOD_SCI 0
`define PDM_MOD_RTC 1
`define PDM_MOD_TMU 2
`define PDM_MOD_UBC 3
`define PDM_MOD_DMA 4
`define PDM_MOD_DAC 5
`define PDM_MOD_ADC 6
`define PDM_MOD_SERIAL_FIFO_IF 7
`define PDM_NUM_MOD 8
// ****************************************
// power modes
// ****************************************
`define PDM_MODE_NORMAL 2'h0
`define PDM_MODE_SLEEP 2'h1
`define PDM_MODE_SW_SOFT_STANDBY_SELECT 2'h2
`define PDM_MODE_HW_SOFT_STANDBY_SELECT 2'h3
`endif

// ### rtl/pdm_mode_fsm.v
`default_nettype none
`include "pdm_consts.vh"
module pdm_mode_fsm (
    input wire clk,
    input wire rst,
    input wire sleep_exec,
    input wire soft_standby_select,
    input wire wake_irq,
    input wire hw_standby_n,
    output reg [1:0] mode_reg
);
    // ****************************************
    // states
    // ****************************************
    localparam [1:0] ST_NORMAL = `PDM_MODE_NORMAL;
    localparam [1:0] ST_SLEEP = `PDM_MODE_SLEEP;
    localparam [1:0] ST_SW_SOFT_STANDBY_SELECT = `PDM_MODE_SW_SOFT_STANDBY_SELECT;
    localparam [1:0] ST_HW_SOFT_STANDBY_SELECT = `PDM_MODE_HW_SOFT_STANDBY_SELECT;
    reg [1:0] mode_next;
    // hardware standby pin beats every other request
    always @* begin
        mode_next = mode_reg;
        case (mode_reg)
            ST_NORMAL: begin
                if (!hw_standby_n) begin
                    mode_next = ST_HW_SOFT_STANDBY_SELECT; // RULE_15
                end else if (sleep_exec && soft_standby_select) begin
                    mode_next = ST_SW_SOFT_STANDBY_SELECT; // RULE_02
                end else if (sleep_exec) begin
                    mode_next = ST_SLEEP; // RULE_01
                end
            end
            ST_SLEEP, ST_SW_SOFT_STANDBY_SELECT: begin
                if (!hw_standby_n) begin
                    mode_next = ST_HW_SOFT_STANDBY_SELECT;
                end else if (wake_irq) begin
                    mode_next = ST_NORMAL; // RULE_15
                end
            end
            // only reset leaves hardware standby
            ST_HW_SOFT_STANDBY_SELECT: begin
                mode_next = ST_HW_SOFT_STANDBY_SELECT; // RULE_15
            end
            default: begin
                mode_next = ST_NORMAL;
            end
        endcase
    end
    // state register
    always @(posedge clk) begin
        if (rst) begin
            mode_reg <= ST_NORMAL;
        end else begin
            mode_reg <= mode_next;
        end
    end
endmodule // pdm_mode_fsm
`default_nettype wire

// ### rtl/pdm_stop_ctrl.v
`default_nettype none
`include "pdm_consts.vh"
module pdm_stop_ctrl (
    input wire [1:0] mode,
    input wire [7:0] stop_bits,
    input wire xtal_keep,
    input wire rtc_start,
    input wire tmu_src_rtc,
    output wire [7:0] clk_en,
    output wire cpg_run,
    output wire xtal_run,
    output wire rtc_count_en,
    output wire rtc_access_en
);
    wire periph_mode;
    wire standby;
    // sleep keeps the clock generator and peripherals running
    assign periph_mode = (mode == `PDM_MODE_NORMAL) || (mode == `PDM_MODE_SLEEP); // RULE_01
    assign standby = (mode == `PDM_MODE_SW_SOFT_STANDBY_SELECT) || (mode == `PDM_MODE_HW_SOFT_STANDBY_SELECT);
    assign cpg_run = !standby; // RULE_02
    assign xtal_run = !standby || xtal_keep; // RULE_04
    // rtc counter survives module stop and, with start set, standby
    assign rtc_count_en = periph_mode || (standby && rtc_start); // RULE_07 RULE_09 RULE_14
    // rtc registers go dark with the rtc module stop bit only
    assign rtc_access_en = !stop_bits[`PDM_MOD_RTC]; // RULE_14
    // ****************************************
    // per-module clock gates
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < `PDM_NUM_MOD; i = i + 1) begin : g_mod
            if (i == `PDM_MOD_TMU) begin : g_tmu
                // timer fed from rtc runs in software standby only
                assign clk_en[i] = !stop_bits[i] && (periph_mode ||
                    (mode == `PDM_MODE_SW_SOFT_STANDBY_SELECT && tmu_src_rtc && rtc_start)); // RULE_08 RULE_09
            end else begin : g_other
                assign clk_en[i] = !stop_bits[i] && periph_mode; // RULE_11 RULE_13
            end
        end
    endgenerate
endmodule // pdm_stop_ctrl
`default_nettype wire

// ### dv/pdm_top_asserts.sv
`default_nettype none
module pdm_top_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rd_data,
    input wire logic sleep_exec,
    input wire logic wake_irq,
    input wire logic hw_standby_pin_n,
    input wire logic processor_state_hi,
    input wire logic processor_state_lo,
    input wire logic cpu_run,
    input wire logic cpg_run,
    input wire logic [7:0] mod_clk_en,
    input wire logic tmu_pin_hold,
    input wire logic sci_pin_reset
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sc_reg;
    logic [4:0] ext_reg;
    wire [1:0] st = {processor_state_hi, processor_state_lo};
    wire [7:0] stop = {ext_reg, sc_reg[2:0]};
    // shadow of the writable bits, reserved ones dropped
    always @(posedge clk) begin
        if (rst) begin
            sc_reg <= 8'h00;
            ext_reg <= 5'h00;
        end else if (wr_en && addr == 4'h0) begin
            sc_reg <= wr_data & 8'h97;
        end else if (wr_en && addr == 4'h1) begin
            ext_reg <= wr_data[4:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // mode outputs lag the request by two edges
    chk_reset_state: assert property (disable iff (1'b0) rst |=> st == 2'b11)
        else $error("state pins not 11 after reset");
    // a low standby pin in the same cycle beats the sleep instruction
    chk_sleep_entry: assert property (sleep_exec && st == 2'b00 && !sc_reg[7]
        && !$past(sleep_exec) && $past(hw_standby_pin_n) && hw_standby_pin_n
        |-> ##2 st == 2'b10 && !cpu_run)
        else $error("sleep not entered");
    chk_soft_standby: assert property (sleep_exec && st == 2'b00 && sc_reg[7]
        && !$past(sleep_exec) && $past(hw_standby_pin_n) && hw_standby_pin_n
        |-> ##2 st == 2'b01 && !cpg_run)
        else $error("software standby not entered");
    chk_wake_exit: assert property (st == 2'b10 && wake_irq && !$past(wake_irq)
        && $past(hw_standby_pin_n) && hw_standby_pin_n |-> ##2 st == 2'b00 && cpu_run)
        else $error("sleep not left on interrupt");
    chk_hw_entry: assert property (!hw_standby_pin_n |-> ##2 st == 2'b01 && !cpg_run)
        else $error("hardware standby not entered");
    chk_rd_value: assert property (rd_en && addr == 4'h0 |=> rd_data == $past(sc_reg))
        else $error("control read mismatch");
    chk_rd_idle: assert property (!$past(rd_en) || $past(addr) > 4'h1 |-> rd_data == 8'h00)
        else $error("read data not zero");
    chk_mod_gate: assert property (st == 2'b00 |-> mod_clk_en == ~$past(stop))
        else $error("module clock enables wrong");
    chk_pin_follow: assert property (st != 2'b11 |-> tmu_pin_hold == $past(sc_reg[2])
        && sci_pin_reset == $past(sc_reg[0]))
        else $error("stopped module pins wrong");
endmodule // pdm_top_asserts
bind pdm_top pdm_top_asserts i_chk (.*);
`default_nettype wire

// ### dv/pdm_cpu_model.sv
`default_nettype none
module pdm_cpu_model (
    input wire logic clk,
    input wire logic [7:0] rd_data,
    output var logic [3:0] addr = 4'h0,
    output var logic [7:0] wr_data = 8'h00,
    output var logic wr_en = 1'b0,
    output var logic rd_en = 1'b0,
    output var logic sleep_exec = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********
    // core bus cycles, one strobe cycle each
    // ********
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 v = rd_data;
    endtask
    task automatic slp();
        @(posedge clk);
        sleep_exec <= 1'b1;
        @(posedge clk);
        sleep_exec <= 1'b0;
    endtask
endmodule // pdm_cpu_model
`default_nettype wire

// ### dv/pdm_top_test.sv
`default_nettype none
module pdm_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wake_irq = 1'b0;
    logic hw_standby_pin_n = 1'b1;
    logic rtc_start = 1'b0;
    logic tmu_src_rtc = 1'b0;
    logic [3:0] addr;
    logic [7:0] wr_data, rd_data, mod_clk_en, d;
    logic wr_en, rd_en, sleep_exec, processor_state_hi, processor_state_lo, cpu_run, cpg_run;
    logic xtal_run, rtc_count_en, rtc_access_en, tmu_pin_hold, sci_pin_reset;
    logic mem_refresh_en, mem_self_refresh;
    int fails = 0;
    int compares = 0;
    // state pins, cpu, cpg, crystal, refresh, self-refresh
    wire [7:0] mo = {1'b0, processor_state_hi, processor_state_lo, cpu_run, cpg_run,
        xtal_run, mem_refresh_en, mem_self_refresh};
    always #10 clk = ~clk;
    pdm_top i_dut (.*);
    pdm_cpu_model i_cpu (.*);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask
    // settle past the edge so flop updates have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wake();
        @(posedge clk);
        wake_irq <= 1'b1;
        @(posedge clk);
        wake_irq <= 1'b0;
        cyc(1);
    endtask
    task automatic t_regs();
        i_cpu.rd(4'h0, d);
        chk(d, 8'h00);
        i_cpu.wr(4'h0, 8'hff);
        i_cpu.rd(4'h0, d);
        chk(d, 8'h97);
        i_cpu.wr(4'h1, 8'hff);
        i_cpu.rd(4'h1, d);
        chk(d, 8'h1f);
        i_cpu.wr(4'h9, 8'hff);
        i_cpu.rd(4'h9, d);
        chk(d, 8'h00);
        $display("t_regs end");
    endtask
    // walk one stop bit across all eight modules
    task automatic t_stop();
        for (int i = 0; i < 8; i++) begin
            i_cpu.wr(4'h0, 8'h07 & (8'h01 << i));
            i_cpu.wr(4'h1, (8'h01 << i) >> 3);
            cyc(1);
            chk(mod_clk_en, ~(8'h01 << i));
            chk1(rtc_access_en, i != 1);
            chk1(tmu_pin_hold, i == 2);
            chk1(sci_pin_reset, i == 0);
        end
        i_cpu.wr(4'h1, 8'h00);
        cyc(1);
        chk(mod_clk_en, 8'hff);
        $display("t_stop end");
    endtask
    task automatic t_sleep();
        i_cpu.slp();
        cyc(1);
        chk(mo, 8'h4e);
        chk(mod_clk_en, 8'hff);
        wake();
        chk(mo, 8'h1e);
        $display("t_sleep end");
    endtask
    // crystal kept and rtc started only on the second pass
    task automatic t_soft();
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            rtc_start <= k[0];
            tmu_src_rtc <= 1'b1;
            i_cpu.wr(4'h0, k[0] ? 8'h90 : 8'h80);
            i_cpu.slp();
            cyc(1);
            chk(mo, k[0] ? 8'h25 : 8'h21);
            chk1(rtc_count_en, k[0]);
            chk1(mod_clk_en[2], k[0]);
            wake();
            chk(mo, 8'h1e);
        end
        i_cpu.wr(4'h0, 8'h00);
        $display("t_soft end");
    endtask
    // only a reset brings the part back from hardware standby
    task automatic t_hw();
        @(posedge clk);
        hw_standby_pin_n <= 1'b0;
        cyc(2);
        chk(mo, 8'h21);
        chk1(rtc_count_en, 1'b1);
        chk1(mod_clk_en[2], 1'b0);
        wake();
        chk(mo, 8'h21);
        @(posedge clk);
        hw_standby_pin_n <= 1'b1;
        rst <= 1'b1;
        cyc(2);
        chk(mo, 8'h6c);
        @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        chk(mo, 8'h1e);
        $display("t_hw end");
    endtask
    task automatic tally_and_finish();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        // reset is sampled high on exactly ten edges
        cyc(9);
        chk(mo, 8'h6c);
        @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_stop();
        t_sleep();
        t_soft();
        t_hw();
        tally_and_finish();
    end
    // hang guard
    initial begin
        #100000;
        fails++;
        tally_and_finish();
    end
endmodule // pdm_top_test
`default_nettype wire
